//--- mfc_mac_flow.sv
// local mac flow control: pause receive and send, half-duplex back-pressure, apb registers
// What this block does
// - pause accepted at own or reserved multicast address
// - control frames recognised only by type 8808
// - pause opcode 0001 is the only control handled
// - parameter is unsigned 16-bit count of quanta
// - new pause reloads timer; zero ends pause
// - pause frames padded with zeros to minimum size
// - pause honoured only when frame crc is good
// - frame in progress finishes before pause applies
// - free pages from ring start, stop, usage
// - send xon when free pages at or below high water
// - send xoff when free reaches high water plus six
// - half duplex: jam forces collision when free pages at or below high water
// - jam only at start of a received frame
// - clean tx or rx frame clears collision count
// - at jam limit let one frame through unjammed
`timescale 1ns/1ps
module mfc_mac_flow #(
  parameter logic [47:0] STATION_ADDR = 48'h020000000001,
  parameter int unsigned JAM_LEN      = mfc_pkg::JAM_BYTES
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  mfc_link_if.dev          link,
  input  wire logic [11:0] i_paddr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_data,
  input  wire logic        i_tx_last,
  output logic             o_tx_ready,
  output logic [7:0]       o_rx_data,
  output logic             o_rx_valid,
  output logic             o_rx_done,
  output logic             o_rx_good,
  output logic             o_paused
);
  import mfc_pkg::*;
  typedef enum {TX_IDLE, TX_USER, TX_CTRL, TX_FCS} mfc_dtx_t;

  if (JAM_LEN < 1 || JAM_LEN > 15) begin : g_chk
    $error("JAM_LEN must be 1..15");
  end

  // ---------------------------------------------------------------
  // registers, receive parse, pause timer, buffer watermarks
  // ---------------------------------------------------------------
  logic [7:0]  start_q, start_d, stop_q, stop_d, jaml_q, jaml_d, hw_q, hw_d;
  logic [7:0]  ctrl_q, ctrl_d, used_q, used_d, col_q, col_d, span, free, aidx, rel;
  logic [31:0] prd_q, prd_d, crc_q, crc_d;
  logic [15:0] ridx_q, ridx_d, pause_q, pause_d;
  logic [47:0] da_q, da_d, hdr_q, hdr_d;
  logic [11:0] div_q, div_d, q_last;
  logic [3:0]  jam_q, jam_d;
  logic        pv_q, pv_d, jmd_q, jmd_d, leak_q, leak_d, fon_q, fon_d;
  logic        xon_q, xon_d, xoff_q, xoff_d, rxv_q, rxv_d, done_q, done_d, good_q, good_d;
  logic [7:0]  rxd_q, rxd_d;
  logic        hit, wr, f_start, f_end, crc_ok, pause_ok, fdx, ctrl_start, tx_done;

  assign aidx    = i_paddr[9:2];
  assign hit     = (i_paddr[11:10] == 2'b00) && (aidx == REG_RX_START || aidx == REG_RX_STOP ||
                   aidx == REG_JAM_LIM || aidx == REG_HI_WATER || aidx == REG_CTRL ||
                   aidx == REG_STATUS || aidx == REG_FREE);
  assign wr      = i_psel && i_penable && i_pwrite && hit;
  assign fdx     = ctrl_q[CTRL_FDX];
  assign span    = stop_q - start_q;
  assign free    = (used_q > span) ? 8'h00 : span - used_q;
  assign f_start = link.p_valid && !pv_q;
  assign f_end   = pv_q && !link.p_valid;
  assign crc_ok  = (crc_q == CRC_RESIDUE);
  assign pause_ok = f_end && fdx && crc_ok && !jmd_q &&
                    (da_q == STATION_ADDR || da_q == PAUSE_MCAST) &&
                    hdr_q[47:32] == TYPE_MAC_CTRL && hdr_q[31:16] == OP_PAUSE;
  assign q_last  = ctrl_q[CTRL_SPD100] ? 12'(Q_CYC_100 - 1) : 12'(Q_CYC_10 - 1);
  assign rel     = (i_pwdata[7:0] > used_q) ? used_q : i_pwdata[7:0];

  always_comb begin
    start_d = start_q; stop_d = stop_q; jaml_d = jaml_q; hw_d = hw_q; ctrl_d = ctrl_q;
    used_d = used_q; col_d = col_q; prd_d = prd_q; crc_d = crc_q; ridx_d = ridx_q;
    pause_d = pause_q; da_d = da_q; hdr_d = hdr_q; div_d = div_q; jam_d = jam_q;
    pv_d = link.p_valid; jmd_d = jmd_q; leak_d = leak_q; fon_d = fon_q;
    xon_d = xon_q; xoff_d = xoff_q; rxv_d = link.p_valid; rxd_d = link.p_data;
    done_d = 1'b0; good_d = 1'b0;
    // apb read data is captured in the setup cycle, zero for unmapped
    if (i_psel && !i_penable) begin
      case (aidx)
        REG_RX_START: prd_d = {24'h000000, start_q};
        REG_RX_STOP:  prd_d = {24'h000000, stop_q};
        REG_JAM_LIM:  prd_d = {24'h000000, jaml_q};
        REG_HI_WATER: prd_d = {24'h000000, hw_q};
        REG_CTRL:     prd_d = {24'h000000, ctrl_q};
        REG_STATUS:   prd_d = {pause_q, col_q, 5'b00000, leak_q, fon_q, (pause_q != 16'h0000)};
        REG_FREE:     prd_d = {24'h000000, free};
        default:      prd_d = 32'h00000000;
      endcase
      if (i_paddr[11:10] != 2'b00) prd_d = 32'h00000000;
    end
    if (wr) begin
      case (aidx)
        REG_RX_START: start_d = i_pwdata[7:0];
        REG_RX_STOP:  stop_d = i_pwdata[7:0];
        REG_JAM_LIM:  jaml_d = i_pwdata[7:0];
        REG_HI_WATER: hw_d = i_pwdata[7:0];
        REG_CTRL:     ctrl_d = i_pwdata[7:0];
        REG_FREE:     used_d = used_q - rel;     // software hands pages back
        default:      ;
      endcase
    end
    // receive byte tracking
    if (link.p_valid) begin
      crc_d = mfc_crc_byte(crc_q, link.p_data);
      if (ridx_q != 16'hFFFF) ridx_d = ridx_q + 16'h0001;
      if (ridx_q < 16'd6) da_d = {da_q[39:0], link.p_data};
      if (ridx_q >= 16'd12 && ridx_q < 16'd18) hdr_d = {hdr_q[39:0], link.p_data};
    end
    // back-pressure only at the head of a new frame, so never late
    if (f_start && !fdx && free <= hw_q) begin
      if (leak_q) leak_d = 1'b0;
      else begin
        jam_d = JAM_LEN[3:0];
        jmd_d = 1'b1;
      end
    end else if (jam_q != 4'h0) jam_d = jam_q - 4'h1;
    if (tx_done) col_d = 8'h00;
    if (f_end) begin
      ridx_d = 16'h0000; crc_d = CRC_INIT; jmd_d = 1'b0; done_d = 1'b1;
      if (jmd_q) begin
        col_d = (col_q == 8'hFF) ? col_q : col_q + 8'h01;
        if (col_q + 8'h01 >= jaml_q) leak_d = 1'b1;
      end else begin
        col_d = 8'h00;
        good_d = crc_ok;
        if (crc_ok && hdr_q[47:32] != TYPE_MAC_CTRL)
          used_d = ((used_d + 8'(ridx_q >> PAGE_SHIFT) + 8'h01) < used_d) ? 8'hFF :
                   used_d + 8'(ridx_q >> PAGE_SHIFT) + 8'h01;
      end
    end
    // pause timer: reload on each good pause, a zero value ends it
    if (pause_ok) begin
      pause_d = hdr_q[15:0];
      div_d = 12'h000;
    end else if (pause_q != 16'h0000) begin
      if (div_q >= q_last) begin
        div_d = 12'h000;
        pause_d = pause_q - 16'h0001;
      end else div_d = div_q + 12'h001;
    end
    // watermark hysteresis; a pending request set here beats the clear
    if (ctrl_start) begin
      xon_d = 1'b0;
      xoff_d = 1'b0;
    end
    if (fdx && !fon_q && free <= hw_q) begin
      fon_d = 1'b1; xon_d = 1'b1; xoff_d = 1'b0;
    end else if (fdx && fon_q && {1'b0, free} >= {1'b0, hw_q} + 9'(HW_HYST)) begin
      fon_d = 1'b0; xoff_d = 1'b1; xon_d = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_q <= RST_START; stop_q <= RST_STOP; jaml_q <= RST_JAM_LIM; hw_q <= RST_HI_WATER;
      ctrl_q <= RST_CTRL; used_q <= 8'h00; col_q <= 8'h00; prd_q <= 32'h00000000;
      crc_q <= CRC_INIT; ridx_q <= 16'h0000; pause_q <= 16'h0000; da_q <= 48'h0;
      hdr_q <= 48'h0; div_q <= 12'h000; jam_q <= 4'h0; pv_q <= 1'b0; jmd_q <= 1'b0;
      leak_q <= 1'b0; fon_q <= 1'b0; xon_q <= 1'b0; xoff_q <= 1'b0; rxv_q <= 1'b0;
      rxd_q <= 8'h00; done_q <= 1'b0; good_q <= 1'b0;
    end else begin
      start_q <= start_d; stop_q <= stop_d; jaml_q <= jaml_d; hw_q <= hw_d;
      ctrl_q <= ctrl_d; used_q <= used_d; col_q <= col_d; prd_q <= prd_d;
      crc_q <= crc_d; ridx_q <= ridx_d; pause_q <= pause_d; da_q <= da_d;
      hdr_q <= hdr_d; div_q <= div_d; jam_q <= jam_d; pv_q <= pv_d; jmd_q <= jmd_d;
      leak_q <= leak_d; fon_q <= fon_d; xon_q <= xon_d; xoff_q <= xoff_d; rxv_q <= rxv_d;
      rxd_q <= rxd_d; done_q <= done_d; good_q <= good_d;
    end
  end

  assign o_prdata   = prd_q;
  assign o_pready   = 1'b1;
  assign o_pslverr  = i_psel && i_penable && !hit;
  assign o_rx_data  = rxd_q;
  assign o_rx_valid = rxv_q;
  assign o_rx_done  = done_q;
  assign o_rx_good  = good_q;
  assign o_paused   = (pause_q != 16'h0000);
  assign link.d_jam = (jam_q != 4'h0);

  // ---------------------------------------------------------------
  // transmit: user frames, pause frames, fcs append
  // ---------------------------------------------------------------
  mfc_dtx_t    tst_q, tst_d;
  logic [5:0]  tidx_q, tidx_d;
  logic [31:0] tcrc_q, tcrc_d, fcs_w;
  logic [15:0] tq_q, tq_d;
  logic [7:0]  txd_q, txd_d, cb;
  logic        txv_q, txv_d;

  assign cb    = mfc_ctrl_byte(tidx_q, PAUSE_MCAST, STATION_ADDR, tq_q);
  assign fcs_w = ~(tcrc_q >> {tidx_q[1:0], 3'b000});

  always_comb begin
    tst_d = tst_q; tidx_d = tidx_q; tcrc_d = tcrc_q; tq_d = tq_q; txd_d = txd_q;
    txv_d = 1'b0; ctrl_start = 1'b0; tx_done = 1'b0;
    case (tst_q)
      TX_IDLE: begin
        tidx_d = 6'd0;
        tcrc_d = CRC_INIT;
        if (fdx && (xon_q || xoff_q)) begin
          ctrl_start = 1'b1;
          tq_d = xon_q ? XON_QUANTA : XOFF_QUANTA;
          tst_d = TX_CTRL;
        end else if (i_tx_valid && pause_q == 16'h0000) tst_d = TX_USER;
      end
      TX_USER: begin
        // a pause landing here waits until this frame is out
        if (i_tx_valid) begin
          txv_d = 1'b1; txd_d = i_tx_data;
          tcrc_d = mfc_crc_byte(tcrc_q, i_tx_data);
          if (i_tx_last) tst_d = TX_FCS;
        end
      end
      TX_CTRL: begin
        txv_d = 1'b1; txd_d = cb;
        tcrc_d = mfc_crc_byte(tcrc_q, cb);
        tidx_d = tidx_q + 6'd1;
        if (tidx_q == 6'(FRAME_MIN - 8'h01)) begin
          tidx_d = 6'd0;
          tst_d = TX_FCS;
        end
      end
      TX_FCS: begin
        txv_d = 1'b1; txd_d = fcs_w[7:0];
        tidx_d = tidx_q + 6'd1;
        if (tidx_q == 6'd3) begin
          tst_d = TX_IDLE;
          tx_done = 1'b1;
        end
      end
      default: tst_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tst_q <= TX_IDLE; tidx_q <= 6'd0; tcrc_q <= CRC_INIT; tq_q <= 16'h0000;
      txd_q <= 8'h00; txv_q <= 1'b0;
    end else begin
      tst_q <= tst_d; tidx_q <= tidx_d; tcrc_q <= tcrc_d; tq_q <= tq_d;
      txd_q <= txd_d; txv_q <= txv_d;
    end
  end

  assign o_tx_ready   = (tst_q == TX_USER);
  assign link.d_data  = txd_q;
  assign link.d_valid = txv_q;
endmodule : mfc_mac_flow

//--- mfc_pkg.sv
// shared constants and frame helpers for the flow-control link ends
package mfc_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address = index * 4) and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RX_START = 8'h01;
  localparam logic [7:0] REG_RX_STOP  = 8'h02;
  localparam logic [7:0] REG_JAM_LIM  = 8'h17;
  localparam logic [7:0] REG_HI_WATER = 8'h1A;
  localparam logic [7:0] REG_CTRL     = 8'h20;
  localparam logic [7:0] REG_STATUS   = 8'h21;
  localparam logic [7:0] REG_FREE     = 8'h22;
  localparam logic [7:0] RST_START    = 8'h40;
  localparam logic [7:0] RST_STOP     = 8'h80;
  localparam logic [7:0] RST_JAM_LIM  = 8'h10;
  localparam logic [7:0] RST_HI_WATER = 8'h04;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam int         CTRL_FDX     = 0;
  localparam int         CTRL_SPD100  = 1;
  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam logic [47:0] PAUSE_MCAST   = 48'h0180C2000001;
  localparam logic [15:0] TYPE_MAC_CTRL = 16'h8808;
  localparam logic [15:0] OP_PAUSE      = 16'h0001;
  localparam logic [15:0] TYPE_DATA     = 16'h0800;
  localparam logic [15:0] XON_QUANTA    = 16'hFFFF;
  localparam logic [15:0] XOFF_QUANTA   = 16'h0000;
  localparam logic [7:0]  FRAME_MIN     = 8'h3C;
  localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY      = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE   = 32'hDEBB20E3;
  // ---------------------------------------------------------------
  // buffer and timing
  // ---------------------------------------------------------------
  localparam int PAGE_SHIFT   = 8;
  localparam int HW_HYST      = 6;
  localparam int JAM_BYTES    = 4;
  localparam int QUANTUM_BITS = 512;
  localparam int BIT_NS_100   = 10;
  localparam int BIT_NS_10    = 100;
  localparam int CLK_NS       = 25;
  localparam int Q_CYC_100    = QUANTUM_BITS * BIT_NS_100 / CLK_NS;
  localparam int Q_CYC_10     = QUANTUM_BITS * BIT_NS_10 / CLK_NS;

  function automatic logic [31:0] mfc_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction : mfc_crc_byte

  // header byte of a pause frame; everything past the parameter is zero pad
  function automatic logic [7:0] mfc_ctrl_byte(input logic [5:0] idx, input logic [47:0] da,
                                               input logic [47:0] sa, input logic [15:0] q);
    logic [47:0] s;
    s = (idx < 6'd6) ? (da << {idx, 3'b000}) : (sa << {idx - 6'd6, 3'b000});
    if (idx < 6'd12) return s[47:40];
    case (idx)
      6'd12:   return TYPE_MAC_CTRL[15:8];
      6'd13:   return TYPE_MAC_CTRL[7:0];
      6'd14:   return OP_PAUSE[15:8];
      6'd15:   return OP_PAUSE[7:0];
      6'd16:   return q[15:8];
      6'd17:   return q[7:0];
      default: return 8'h00;
    endcase
  endfunction : mfc_ctrl_byte
endpackage : mfc_pkg

//--- mfc_link_if.sv
// byte-wide link between the local mac and the remote station
`timescale 1ns/1ps
interface mfc_link_if;
  logic [7:0] d_data;
  logic       d_valid;
  logic       d_jam;
  logic [7:0] p_data;
  logic       p_valid;
  modport dev (output d_data, d_valid, d_jam, input p_data, p_valid);
  modport peer (input d_data, d_valid, d_jam, output p_data, p_valid);
endinterface : mfc_link_if

//--- mfc_peer.sv
// remote station end: sends pause and data frames, reports pause frames received
`timescale 1ns/1ps
module mfc_peer #(
  parameter logic [47:0] PEER_ADDR = 48'h020000000002,
  parameter logic [47:0] DEV_ADDR  = 48'h020000000001
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  mfc_link_if.peer         link,
  input  wire logic        i_send_pause,
  input  wire logic [15:0] i_pause_quanta,
  input  wire logic        i_pause_mcast,
  input  wire logic        i_send_data,
  input  wire logic [7:0]  i_data_len,
  output logic             o_busy,
  output logic             o_sent,
  output logic             o_collision,
  output logic             o_rx_pause,
  output logic [15:0]      o_rx_quanta,
  output logic             o_rx_fcs_ok
);
  import mfc_pkg::*;
  typedef enum {P_IDLE, P_BODY, P_FCS} mfc_ptx_t;

  // ---------------------------------------------------------------
  // transmit
  // ---------------------------------------------------------------
  mfc_ptx_t    st_q, st_d;
  logic [7:0]  idx_q, idx_d, len_q, len_d, pd_q, pd_d, hb, byte_w;
  logic [31:0] crc_q, crc_d, fcs_w;
  logic [15:0] q_q, q_d;
  logic [47:0] da_q, da_d;
  logic        pf_q, pf_d, pv_q, pv_d, sent_q, sent_d, col_q, col_d;

  assign hb     = mfc_ctrl_byte(idx_q[5:0], da_q, PEER_ADDR, q_q);
  assign byte_w = (pf_q || idx_q < 8'd12) ? hb : (idx_q == 8'd12) ? TYPE_DATA[15:8] :
                  (idx_q == 8'd13) ? TYPE_DATA[7:0] : idx_q;
  assign fcs_w  = ~(crc_q >> {idx_q[1:0], 3'b000});

  always_comb begin
    st_d = st_q; idx_d = idx_q; len_d = len_q; pd_d = pd_q; crc_d = crc_q;
    q_d = q_q; da_d = da_q; pf_d = pf_q; pv_d = 1'b0; sent_d = 1'b0; col_d = 1'b0;
    case (st_q)
      P_IDLE: begin
        idx_d = 8'h00;
        crc_d = CRC_INIT;
        if (!link.d_jam && i_send_pause) begin
          pf_d = 1'b1; q_d = i_pause_quanta; len_d = FRAME_MIN;
          da_d = i_pause_mcast ? PAUSE_MCAST : DEV_ADDR;
          st_d = P_BODY;
        end else if (!link.d_jam && i_send_data) begin
          pf_d = 1'b0; da_d = DEV_ADDR; st_d = P_BODY;
          len_d = (i_data_len < FRAME_MIN) ? FRAME_MIN : i_data_len;
        end
      end
      P_BODY: begin
        pv_d = 1'b1; pd_d = byte_w;
        crc_d = mfc_crc_byte(crc_q, byte_w);
        idx_d = idx_q + 8'h01;
        if (idx_q == len_q - 8'h01) begin
          idx_d = 8'h00; st_d = P_FCS;
        end
      end
      P_FCS: begin
        pv_d = 1'b1; pd_d = fcs_w[7:0];
        idx_d = idx_q + 8'h01;
        if (idx_q == 8'h03) begin
          st_d = P_IDLE; sent_d = 1'b1;
        end
      end
      default: st_d = P_IDLE;
    endcase
    // jam seen while sending: abort and let the user retry later
    if (link.d_jam && st_q != P_IDLE) begin
      st_d = P_IDLE; pv_d = 1'b0; col_d = 1'b1; sent_d = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= P_IDLE; idx_q <= 8'h00; len_q <= 8'h00; pd_q <= 8'h00; crc_q <= CRC_INIT;
      q_q <= 16'h0000; da_q <= 48'h0; pf_q <= 1'b0; pv_q <= 1'b0; sent_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      st_q <= st_d; idx_q <= idx_d; len_q <= len_d; pd_q <= pd_d; crc_q <= crc_d;
      q_q <= q_d; da_q <= da_d; pf_q <= pf_d; pv_q <= pv_d; sent_q <= sent_d;
      col_q <= col_d;
    end
  end

  assign link.p_data  = pd_q;
  assign link.p_valid = pv_q;
  assign o_busy       = (st_q != P_IDLE);
  assign o_sent       = sent_q;
  assign o_collision  = col_q;

  // ---------------------------------------------------------------
  // receive: spot pause frames sent by the local mac
  // ---------------------------------------------------------------
  logic [7:0]  ri_q, ri_d;
  logic [31:0] rc_q, rc_d;
  logic [47:0] rda_q, rda_d, rh_q, rh_d;
  logic        rv_q, rv_d, rp_q, rp_d, rok_q, rok_d;
  logic [15:0] rq_q, rq_d;

  always_comb begin
    ri_d = ri_q; rc_d = rc_q; rda_d = rda_q; rh_d = rh_q; rv_d = link.d_valid;
    rp_d = 1'b0; rok_d = rok_q; rq_d = rq_q;
    if (link.d_valid) begin
      rc_d = mfc_crc_byte(rc_q, link.d_data);
      if (ri_q != 8'hFF) ri_d = ri_q + 8'h01;
      if (ri_q < 8'd6) rda_d = {rda_q[39:0], link.d_data};
      if (ri_q >= 8'd12 && ri_q < 8'd18) rh_d = {rh_q[39:0], link.d_data};
    end else if (rv_q) begin
      ri_d = 8'h00; rc_d = CRC_INIT;
      if ((rda_q == PEER_ADDR || rda_q == PAUSE_MCAST) &&
          rh_q[47:32] == TYPE_MAC_CTRL && rh_q[31:16] == OP_PAUSE) begin
        rp_d = 1'b1; rq_d = rh_q[15:0]; rok_d = (rc_q == CRC_RESIDUE);
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ri_q <= 8'h00; rc_q <= CRC_INIT; rda_q <= 48'h0; rh_q <= 48'h0; rv_q <= 1'b0;
      rp_q <= 1'b0; rok_q <= 1'b0; rq_q <= 16'h0000;
    end else begin
      ri_q <= ri_d; rc_q <= rc_d; rda_q <= rda_d; rh_q <= rh_d; rv_q <= rv_d;
      rp_q <= rp_d; rok_q <= rok_d; rq_q <= rq_d;
    end
  end

  assign o_rx_pause  = rp_q;
  assign o_rx_quanta = rq_q;
  assign o_rx_fcs_ok = rok_q;
endmodule : mfc_peer

//--- mfc_flow_asserts.sv
// link-level checker for the two flow-control ends
`timescale 1ns/1ps
module mfc_flow_asserts #(
  parameter int unsigned JAM_LEN = 4
) (
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  input wire logic [7:0] d_data,
  input wire logic       d_valid,
  input wire logic       d_jam,
  input wire logic       p_valid
);
  logic [7:0] cnt_d, cnt_q, jcnt_d, jcnt_q;
  logic       mc_d, mc_q;
  // byte index in the current device frame; mc_q marks a multicast control frame
  always_comb begin
    cnt_d  = d_valid ? cnt_q + 8'h01 : 8'h00;
    jcnt_d = d_jam ? jcnt_q + 8'h01 : 8'h00;
    mc_d   = (cnt_q == 8'h00) ? (d_data == 8'h01) : mc_q;
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q  <= 8'h00;
      jcnt_q <= 8'h00;
      mc_q   <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      jcnt_q <= jcnt_d;
      mc_q   <= mc_d;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  property p_dest; d_valid && cnt_q == 8'h00 && d_data == 8'h01 |=> d_data == 8'h80
    ##1 d_data == 8'hC2 ##1 d_data == 8'h00 ##1 d_data == 8'h00 ##1 d_data == 8'h01; endproperty
  a_dest: assert property (p_dest) else $error("control frame address wrong");
  property p_type; d_valid && mc_q && cnt_q == 8'h0C |->
    d_data == 8'h88 ##1 d_data == 8'h08; endproperty
  a_type: assert property (p_type) else $error("control frame type wrong");
  property p_op; d_valid && mc_q && cnt_q == 8'h0E |->
    d_data == 8'h00 ##1 d_data == 8'h01; endproperty
  a_op: assert property (p_op) else $error("control opcode wrong");
  property p_param; d_valid && mc_q && cnt_q == 8'h10 |-> (d_data == 8'hFF ##1 d_data == 8'hFF)
    or (d_data == 8'h00 ##1 d_data == 8'h00); endproperty
  a_param: assert property (p_param) else $error("flow frame parameter wrong");
  property p_pad; d_valid && mc_q && cnt_q >= 8'h12 && cnt_q < 8'h3C |->
    d_data == 8'h00; endproperty
  a_pad: assert property (p_pad) else $error("control pad not zero");
  property p_min_len; $fell(d_valid) |-> cnt_q >= 8'h40; endproperty
  a_min_len: assert property (p_min_len) else $error("device frame cut short");
  property p_jam_len; $fell(d_jam) |-> jcnt_q == JAM_LEN; endproperty
  a_jam_len: assert property (p_jam_len) else $error("jam length wrong");
  property p_jam_rx; $rose(d_jam) |-> $past(p_valid); endproperty
  a_jam_rx: assert property (p_jam_rx) else $error("jam outside receive");
  property p_back_off; $rose(d_jam) |-> ##[0:2] !p_valid; endproperty
  a_back_off: assert property (p_back_off) else $error("peer kept sending");
endmodule : mfc_flow_asserts

//--- mfc_mac_flow_tb.sv
// self-checking bench: device and peer ends, apb host, user transmit
`timescale 1ns/1ps
module mfc_mac_flow_tb;
  import mfc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, c;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, tx_valid = 1'b0, tx_last = 1'b0, tx_ready, paused;
  logic [7:0]  tx_data = 8'h02;
  logic        s_pause = 1'b0, mcast = 1'b0, s_data = 1'b0, sent, coll, rx_p, fcs_ok;
  logic        rx_done, rx_good;
  logic [1:0]  g;
  logic [15:0] quanta = 16'h0, rx_q;
  int          bad_count = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  mfc_link_if link ();
  mfc_mac_flow mfc_mac_flow_i (.i_sys_clk(clk), .i_sys_rst(rst), .link(link), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_rx_data(), .o_rx_valid(),
    .o_rx_done(rx_done), .o_rx_good(rx_good), .o_paused(paused));
  mfc_peer mfc_peer_i (.i_sys_clk(clk), .i_sys_rst(rst), .link(link), .i_send_pause(s_pause),
    .i_pause_quanta(quanta), .i_pause_mcast(mcast), .i_send_data(s_data), .i_data_len(8'h3C),
    .o_busy(), .o_sent(sent), .o_collision(coll), .o_rx_pause(rx_p), .o_rx_quanta(rx_q),
    .o_rx_fcs_ok(fcs_ok));
  mfc_flow_asserts #(.JAM_LEN(JAM_BYTES)) mfc_flow_asserts_i (.i_sys_clk(clk), .i_sys_rst(rst),
    .d_data(link.d_data), .d_valid(link.d_valid), .d_jam(link.d_jam), .p_valid(link.p_valid));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // answer taken at the rising edge that samples pready high
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic peer(input logic p, input logic [15:0] q, input logic m);
    @(posedge clk);
    s_pause <= p; s_data <= !p; quanta <= q; mcast <= m;
    @(posedge clk);
    s_pause <= 1'b0; s_data <= 1'b0;
    g = 2'b00;
    do @(negedge clk); while (sent !== 1'b1 && coll !== 1'b1);
    c = coll;
    // device end-of-frame pulses land inside these cycles
    repeat (4) begin
      @(negedge clk);
      g = g | {rx_done, rx_good};
    end
  endtask : peer
  // waits for the device's next flow frame to reach the peer
  task automatic flow(input logic [15:0] q);
    do @(negedge clk); while (rx_p !== 1'b1);
    chk({16'h0, rx_q}, {16'h0, q});
    chk({31'h0, fcs_ok}, 32'h1);
  endtask : flow
  task automatic t_regs;
    logic [7:0] ix [5] = '{REG_RX_START, REG_RX_STOP, REG_JAM_LIM, REG_HI_WATER, REG_FREE};
    logic [7:0] rv [5] = '{RST_START, RST_STOP, RST_JAM_LIM, RST_HI_WATER, 8'h40};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ix[i], 32'h0);
      chk(rd, {24'h0, rv[i]});
    end
    apb(1'b1, 8'hFC, 32'hFF);
    chk({31'h0, er}, 32'h1);
  endtask : t_regs
  task automatic t_pause;
    apb(1'b1, REG_CTRL, 32'h3);
    peer(1'b1, 16'h0002, 1'b1);
    chk({31'h0, paused}, 32'h1);
    chk({30'h0, g}, 32'h3);
    repeat (300) @(negedge clk);
    chk({31'h0, paused}, 32'h1);
    repeat (150) @(negedge clk);
    chk({31'h0, paused}, 32'h0);
    peer(1'b1, 16'hFFFF, 1'b0);
    chk({31'h0, paused}, 32'h1);
    peer(1'b1, 16'h0000, 1'b1);
    chk({31'h0, paused}, 32'h0);
  endtask : t_pause
  task automatic t_tx_pause;
    fork
      peer(1'b1, 16'hFFFF, 1'b1);
      begin
        repeat (30) @(posedge clk);
        for (int n = 0; n < 60;) begin
          @(posedge clk);
          tx_valid <= 1'b1; tx_data <= n[7:0] + 8'h02; tx_last <= (n == 59);
          @(negedge clk);
          if (tx_ready === 1'b1) n++;
        end
        @(posedge clk);
        tx_valid <= 1'b0; tx_last <= 1'b0;
      end
    join
    chk({31'h0, paused}, 32'h1);
    peer(1'b1, 16'h0000, 1'b1);
  endtask : t_tx_pause
  task automatic t_water;
    apb(1'b1, REG_HI_WATER, 32'h3F);
    peer(1'b0, 16'h0, 1'b0);
    flow(XON_QUANTA);
    apb(1'b0, REG_FREE, 32'h0);
    chk(rd, 32'h3F);
    apb(1'b1, REG_HI_WATER, 32'h3A);
    apb(1'b1, REG_FREE, 32'h1);
    flow(XOFF_QUANTA);
  endtask : t_water
  task automatic t_jam;
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_HI_WATER, 32'hFF);
    apb(1'b1, REG_JAM_LIM, 32'h2);
    for (int i = 1; i < 4; i++) begin
      peer(1'b0, 16'h0, 1'b0);
      chk({31'h0, c}, {31'h0, i < 3});
      chk({30'h0, g}, {30'h0, 1'b1, i == 3});
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd & 32'hFF04, (i == 2) ? 32'h0204 : {23'h0, i == 1, 8'h0});
    end
  endtask : t_jam
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #500000;
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_pause;
    t_tx_pause;
    t_water;
    t_jam;
    print_verdict;
  end
endmodule : mfc_mac_flow_tb
